// file: core/swp_pkg.sv
package swp_pkg;
	// register bus widths
	localparam int             ADDR_W          = 8;
	localparam int             DATA_W          = 8;
	localparam int             NUM_PORTS       = 2;

	// register offsets
	localparam logic [7:0]     OFS_P1_CTRL     = 8'h1d;
	localparam logic [7:0]     OFS_P2_CTRL     = 8'h2d;
	localparam logic [7:0]     OFS_PWR_MODE    = 8'hc3;
	localparam logic [7:0]     OFS_SLEEP_DLY   = 8'hc4;

	// field positions
	localparam int             BIT_PORT_PD     = 3;
	localparam int             BIT_PLL_DIS     = 2;
	localparam int             BIT_LP_STAT     = 7;

	// reset values
	localparam logic [7:0]     RST_PORT_CTRL   = 8'h00;
	localparam logic [6:0]     RST_PWR_MODE    = 7'h00;
	localparam logic [7:0]     RST_SLEEP_DLY   = 8'h50;

	// power-mode codes
	localparam logic [1:0]     MODE_NORMAL     = 2'h0;
	localparam logic [1:0]     MODE_ENERGY     = 2'h1;
	localparam logic [1:0]     MODE_SOFT_PD    = 2'h2;
	localparam logic [1:0]     MODE_PWR_SAVE   = 2'h3;

	// timing
	localparam int             CLK_FREQ_HZ     = 40_000_000;
	localparam int             PULSE_WIDTH_NS  = 120;
	localparam int             PULSE_RATE_HZ   = 1;
	localparam int             SLEEP_UNIT_US   = 1000;
	localparam int             PULSE_WIDTH_CYC = (PULSE_WIDTH_NS * (CLK_FREQ_HZ / 1_000_000)
		+ 999) / 1000;
	localparam int             PULSE_PERIOD_CYC = CLK_FREQ_HZ / PULSE_RATE_HZ;
	localparam int             SLEEP_UNIT_CYC  = SLEEP_UNIT_US * (CLK_FREQ_HZ / 1_000_000);

	// power states
	typedef enum logic [2:0] {
		ST_NORMAL,
		ST_ED_AWAKE,
		ST_ED_SLEEP,
		ST_SOFT_PD,
		ST_PS_WAIT,
		ST_PS_SAVE
	} swp_state_type;
endpackage : swp_pkg

// file: core/swp_idle_timer.sv
`timescale 1ns/10ps
module swp_idle_timer #(
	parameter int UNIT_CYC = 40000
) (
	input  logic       clk,
	input  logic       rst_n,
	input  logic       run,
	input  logic [7:0] delay,
	output logic       expired
);
	localparam int PW = $clog2(UNIT_CYC + 1);

	logic [PW-1:0] pre_r;       // unit prescaler
	logic [PW-1:0] pre_nxt;
	logic [8:0]    cnt_r;       // idle units seen, saturating
	logic [8:0]    cnt_nxt;
	logic          expired_r;   // idle time longer than delay
	logic          expired_nxt;

	// count idle units while running, clear otherwise
	always_comb begin
		pre_nxt     = pre_r;
		cnt_nxt     = cnt_r;
		expired_nxt = run && (cnt_r > {1'b0, delay});
		if (!run) begin
			pre_nxt = '0;
			cnt_nxt = '0;
		end else if (pre_r == PW'(UNIT_CYC - 1)) begin
			pre_nxt = '0;
			// saturate so a long idle cannot wrap
			if (cnt_r != 9'h1ff) begin
				cnt_nxt = cnt_r + 9'h001;
			end
		end else begin
			pre_nxt = pre_r + PW'(1);
		end
	end

	// registers
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pre_r     <= '0;
			cnt_r     <= '0;
			expired_r <= 1'b0;
		end else begin
			pre_r     <= pre_nxt;
			cnt_r     <= cnt_nxt;
			expired_r <= expired_nxt;
		end
	end

	assign expired = expired_r;
endmodule : swp_idle_timer

// file: core/swp_pulse_gen.sv
`timescale 1ns/10ps
module swp_pulse_gen #(
	parameter int PERIOD_CYC = 40000000,
	parameter int WIDTH_CYC  = 5
) (
	input  logic clk,
	input  logic rst_n,
	input  logic en,
	output logic pulse
);
	localparam int CW = $clog2(PERIOD_CYC + 1);

	logic [CW-1:0] cnt_r;     // position within the period
	logic [CW-1:0] cnt_nxt;
	logic          pulse_r;   // line pulse, high at period start
	logic          pulse_nxt;

	// free period counter, restarted whenever disabled
	always_comb begin
		pulse_nxt = en && (cnt_r < CW'(WIDTH_CYC));
		if (!en || (cnt_r == CW'(PERIOD_CYC - 1))) begin
			cnt_nxt = '0;
		end else begin
			cnt_nxt = cnt_r + CW'(1);
		end
	end

	// registers
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_r   <= '0;
			pulse_r <= 1'b0;
		end else begin
			cnt_r   <= cnt_nxt;
			pulse_r <= pulse_nxt;
		end
	end

	assign pulse = pulse_r;
endmodule : swp_pulse_gen

// file: core/swp_power_ctrl.sv
// Overview of operation
// - two-bit field picks one of four modes
// - port control bit 3 powers down PHY
// - mode field resets to normal
// - normal: clocks, PHY, MAC, host all on
// - energy-detect has awake and low-power states
// - sleep after idle longer than go-sleep delay
// - low power: only energy detector and PLL; wake on energy
// - low power: 120 ns pulse once per second
// - bit 2 also stops PLL in energy-detect
// - soft power-down stops clocks, PHY, MAC
// - writing 00 leaves soft power-down
// - power-saving needs 11, autoneg, no cable
// - power-saving turns off only unused receiver
// - cable or link attempt wakes the PHY
// - management PHY register also powers down port
`timescale 1ns/10ps
module swp_power_ctrl
#(
	parameter int PULSE_PERIOD = swp_pkg::PULSE_PERIOD_CYC,
	parameter int SLEEP_UNIT   = swp_pkg::SLEEP_UNIT_CYC
) (
	input  logic                           clk,
	input  logic                           resetn,
	input  logic [swp_pkg::ADDR_W-1:0]     addr,
	input  logic [swp_pkg::DATA_W-1:0]     wdata,
	input  logic                           wr,
	input  logic                           rd,
	output logic [swp_pkg::DATA_W-1:0]     rdata,
	input  logic [swp_pkg::NUM_PORTS-1:0]  energy,
	input  logic                           link_attempt,
	input  logic                           an_enable,
	input  logic [swp_pkg::NUM_PORTS-1:0]  miim_pdown,
	output logic                           pll_en,
	output logic                           mac_en,
	output logic                           host_if_en,
	output logic [swp_pkg::NUM_PORTS-1:0]  phy_tx_en,
	output logic [swp_pkg::NUM_PORTS-1:0]  phy_rx_en,
	output logic                           energy_det_en,
	output logic                           low_power,
	output logic                           line_pulse
);
	import swp_pkg::*;

	// reset synchroniser
	logic          rst_meta_r;        // first stage, read only by second
	logic          rst_n_r;           // released reset used everywhere
	// software registers
	logic [7:0]    p1_ctrl_r;         // port 1 phy control
	logic [7:0]    p1_ctrl_nxt;
	logic [7:0]    p2_ctrl_r;         // port 2 phy control
	logic [7:0]    p2_ctrl_nxt;
	logic [6:0]    pmode_r;           // power mode control, writable bits
	logic [6:0]    pmode_nxt;
	logic [7:0]    sleep_dly_r;       // go-sleep delay
	logic [7:0]    sleep_dly_nxt;
	logic [7:0]    rdata_r;           // read data, one cycle after strobe
	logic [7:0]    rdata_nxt;
	// power state and derived enables
	swp_state_type state_r;
	swp_state_type state_nxt;
	logic          pll_en_r;
	logic          pll_en_nxt;
	logic          mac_en_r;
	logic          mac_en_nxt;
	logic          host_en_r;
	logic          host_en_nxt;
	logic [1:0]    tx_en_r;
	logic [1:0]    tx_en_nxt;
	logic [1:0]    rx_en_r;
	logic [1:0]    rx_en_nxt;
	logic          ed_en_r;
	logic          ed_en_nxt;
	logic          lp_r;
	logic          lp_nxt;
	logic [1:0]    mode;              // selected power mode
	logic          energy_any;        // energy on either cable
	logic          idle_run;          // idle timer counting
	logic          idle_expired;      // idle longer than delay
	logic          pulse_en;          // line pulses wanted
	logic [1:0]    port_off;          // per-port power-down request
	logic          pwr_wr;            // write to power mode register
	assign mode       = pmode_r[1:0];
	assign energy_any = |energy;
	assign pwr_wr     = wr && (addr == OFS_PWR_MODE);
	assign port_off   = {p2_ctrl_r[BIT_PORT_PD] | miim_pdown[1],
		p1_ctrl_r[BIT_PORT_PD] | miim_pdown[0]};
	// state to enter when the host selects a mode
	function automatic swp_state_type entry_state(input logic [1:0] m);
		case (m)
			MODE_ENERGY:   entry_state = ST_ED_AWAKE;
			MODE_SOFT_PD:  entry_state = ST_SOFT_PD;
			MODE_PWR_SAVE: entry_state = ST_PS_WAIT;
			default:       entry_state = ST_NORMAL;
		endcase
	endfunction : entry_state
	// reset release through two flops
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rst_meta_r <= 1'b0;
			rst_n_r    <= 1'b0;
		end else begin
			rst_meta_r <= 1'b1;
			rst_n_r    <= rst_meta_r;
		end
	end
	// register writes and reads
	always_comb begin
		p1_ctrl_nxt   = p1_ctrl_r;
		p2_ctrl_nxt   = p2_ctrl_r;
		pmode_nxt     = pmode_r;
		sleep_dly_nxt = sleep_dly_r;
		rdata_nxt     = rdata_r;
		// mode field moves only on a host write
		if (wr) begin
			case (addr)
				OFS_P1_CTRL:   p1_ctrl_nxt   = wdata;
				OFS_P2_CTRL:   p2_ctrl_nxt   = wdata;
				OFS_PWR_MODE:  pmode_nxt     = wdata[6:0];
				OFS_SLEEP_DLY: sleep_dly_nxt = wdata;
				default:       ;
			endcase
		end
		// unmapped reads return zero
		if (rd) begin
			case (addr)
				OFS_P1_CTRL:   rdata_nxt = p1_ctrl_r;
				OFS_P2_CTRL:   rdata_nxt = p2_ctrl_r;
				OFS_PWR_MODE:  rdata_nxt = {lp_r, pmode_r};
				OFS_SLEEP_DLY: rdata_nxt = sleep_dly_r;
				default:       rdata_nxt = 8'h00;
			endcase
		end
	end

	// register file flops, all contents kept in every power state
	always_ff @(posedge clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			p1_ctrl_r   <= RST_PORT_CTRL;
			p2_ctrl_r   <= RST_PORT_CTRL;
			pmode_r     <= RST_PWR_MODE;
			sleep_dly_r <= RST_SLEEP_DLY;
			rdata_r     <= 8'h00;
		end else begin
			p1_ctrl_r   <= p1_ctrl_nxt;
			p2_ctrl_r   <= p2_ctrl_nxt;
			pmode_r     <= pmode_nxt;
			sleep_dly_r <= sleep_dly_nxt;
			rdata_r     <= rdata_nxt;
		end
	end

	// power state machine
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			// awake half of energy-detect
			ST_ED_AWAKE: begin
				if (mode != MODE_ENERGY) begin
					state_nxt = entry_state(mode);
				end else if (idle_expired) begin
					state_nxt = ST_ED_SLEEP;
				end
			end
			// low-power half of energy-detect
			ST_ED_SLEEP: begin
				if (mode != MODE_ENERGY) begin
					state_nxt = entry_state(mode);
				end else if (energy_any) begin
					state_nxt = ST_ED_AWAKE;
				end
			end
			// power-saving armed but line still in use
			ST_PS_WAIT: begin
				if (mode != MODE_PWR_SAVE) begin
					state_nxt = entry_state(mode);
				end else if (an_enable && !energy_any && !link_attempt) begin
					state_nxt = ST_PS_SAVE;
				end
			end
			// receiver sections off
			ST_PS_SAVE: begin
				if (mode != MODE_PWR_SAVE) begin
					state_nxt = entry_state(mode);
				end else if (energy_any || link_attempt || !an_enable) begin
					state_nxt = ST_PS_WAIT;
				end
			end
			// normal and soft power-down follow the field directly
			default: begin
				state_nxt = entry_state(mode);
			end
		endcase
	end

	// block enables per state
	always_comb begin
		pll_en_nxt  = 1'b1;
		mac_en_nxt  = 1'b1;
		host_en_nxt = 1'b1;
		tx_en_nxt   = ~port_off;
		rx_en_nxt   = ~port_off;
		ed_en_nxt   = 1'b0;
		lp_nxt      = 1'b0;
		case (state_r)
			// energy detector stays on, and the PLL too unless bit 2 is set
			ST_ED_SLEEP: begin
				pll_en_nxt  = ~pmode_r[BIT_PLL_DIS];
				mac_en_nxt  = 1'b0;
				host_en_nxt = 1'b0;
				tx_en_nxt   = 2'h0;
				rx_en_nxt   = 2'h0;
				ed_en_nxt   = 1'b1;
				lp_nxt      = 1'b1;
			end
			// everything stopped
			ST_SOFT_PD: begin
				pll_en_nxt  = 1'b0;
				mac_en_nxt  = 1'b0;
				host_en_nxt = 1'b0;
				tx_en_nxt   = 2'h0;
				rx_en_nxt   = 2'h0;
				lp_nxt      = 1'b1;
			end
			// transmitter kept, unused receiver off
			ST_PS_SAVE: begin
				rx_en_nxt = 2'h0;
				ed_en_nxt = 1'b1;
				lp_nxt    = 1'b1;
			end
			// normal, awake and waiting states run fully
			default: pll_en_nxt = 1'b1;
		endcase
	end

	// state and enable flops
	always_ff @(posedge clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			state_r   <= ST_NORMAL;
			pll_en_r  <= 1'b1;
			mac_en_r  <= 1'b1;
			host_en_r <= 1'b1;
			tx_en_r   <= 2'h3;
			rx_en_r   <= 2'h3;
			ed_en_r   <= 1'b0;
			lp_r      <= 1'b0;
		end else begin
			state_r   <= state_nxt;
			pll_en_r  <= pll_en_nxt;
			mac_en_r  <= mac_en_nxt;
			host_en_r <= host_en_nxt;
			tx_en_r   <= tx_en_nxt;
			rx_en_r   <= rx_en_nxt;
			ed_en_r   <= ed_en_nxt;
			lp_r      <= lp_nxt;
		end
	end

	assign idle_run = (state_r == ST_ED_AWAKE) && !energy_any;
	assign pulse_en = (state_r == ST_ED_SLEEP);
	// idle time against the go-sleep delay
	swp_idle_timer #(
		.UNIT_CYC (SLEEP_UNIT)
	) u_idle (
		.clk     (clk),
		.rst_n   (rst_n_r),
		.run     (idle_run),
		.delay   (sleep_dly_r),
		.expired (idle_expired)
	);

	// link pulses while asleep
	swp_pulse_gen #(
		.PERIOD_CYC (PULSE_PERIOD),
		.WIDTH_CYC  (PULSE_WIDTH_CYC)
	) u_pulse (
		.clk   (clk),
		.rst_n (rst_n_r),
		.en    (pulse_en),
		.pulse (line_pulse)
	);

	assign rdata         = rdata_r;
	assign pll_en        = pll_en_r;
	assign mac_en        = mac_en_r;
	assign host_if_en    = host_en_r;
	assign phy_tx_en     = tx_en_r;
	assign phy_rx_en     = rx_en_r;
	assign energy_det_en = ed_en_r;
	assign low_power     = lp_r;

	// checks
	a_mode_reset: assert property (@(posedge clk) $rose(rst_n_r) |-> (mode == MODE_NORMAL))
		else $error("mode not normal after reset");
	a_mode_write: assert property (@(posedge clk) disable iff (!rst_n_r)
		pwr_wr |=> (mode == $past(wdata[1:0])))
		else $error("mode field did not take write");
	a_mode_hold: assert property (@(posedge clk) disable iff (!rst_n_r)
		!pwr_wr |=> $stable(mode))
		else $error("mode field changed without write");
	a_normal_on: assert property (@(posedge clk) disable iff (!rst_n_r)
		(state_r == ST_NORMAL) |=> (pll_en && mac_en && host_if_en))
		else $error("normal mode block disabled");
	a_port_down: assert property (@(posedge clk) disable iff (!rst_n_r)
		port_off[0] |=> !phy_tx_en[0] && !phy_rx_en[0])
		else $error("port 1 phy not powered down");
	a_soft_off: assert property (@(posedge clk) disable iff (!rst_n_r)
		(state_r == ST_SOFT_PD) |=> (!pll_en && !mac_en && phy_tx_en == 2'h0))
		else $error("soft power-down left blocks on");
	a_soft_exit: assert property (@(posedge clk) disable iff (!rst_n_r)
		(state_r == ST_SOFT_PD) && pwr_wr && (wdata[1:0] == MODE_NORMAL)
		|=> ##1 (state_r == ST_NORMAL))
		else $error("soft power-down not left");
	a_ed_wake: assert property (@(posedge clk) disable iff (!rst_n_r)
		(state_r == ST_ED_SLEEP) && energy_any && (mode == MODE_ENERGY) && !pwr_wr
		|=> (state_r == ST_ED_AWAKE) ##1 mac_en)
		else $error("energy did not wake device");
	a_pll_dis: assert property (@(posedge clk) disable iff (!rst_n_r)
		(state_r == ST_ED_SLEEP) && pmode_r[BIT_PLL_DIS] |=> !pll_en)
		else $error("pll not disabled in sleep");
	a_ps_keep: assert property (@(posedge clk) disable iff (!rst_n_r)
		(state_r == ST_PS_SAVE) |=> (pll_en && mac_en && host_if_en && phy_rx_en == 2'h0))
		else $error("power-saving enables wrong");
	a_ps_enter: assert property (@(posedge clk) disable iff (!rst_n_r)
		(state_r != ST_PS_SAVE) ##1 (state_r == ST_PS_SAVE)
		|-> $past(mode == MODE_PWR_SAVE && an_enable && !energy_any))
		else $error("power-saving entered without conditions");
	c_ed_sleep: cover property (@(posedge clk) disable iff (!rst_n_r)
		(state_r == ST_ED_AWAKE) ##1 (state_r == ST_ED_SLEEP));
	c_soft_pd: cover property (@(posedge clk) disable iff (!rst_n_r)
		(state_r == ST_SOFT_PD) ##1 (state_r == ST_NORMAL));
	c_ps_wake: cover property (@(posedge clk) disable iff (!rst_n_r)
		(state_r == ST_PS_SAVE) ##1 (state_r == ST_PS_WAIT));
endmodule : swp_power_ctrl

// file: tb/swp_host_model.sv
`timescale 1ns/10ps
// host processor model: masters the register port, one strobe at a time
module swp_host_model (
	input  logic                       clk,
	output logic [swp_pkg::ADDR_W-1:0] addr,
	output logic [swp_pkg::DATA_W-1:0] wdata,
	output logic                       wr,
	output logic                       rd,
	input  logic [swp_pkg::DATA_W-1:0] rdata
);
	import swp_pkg::*;

	// idle bus at time zero
	initial begin
		addr  = 8'h00;
		wdata = 8'h00;
		wr    = 1'b0;
		rd    = 1'b0;
	end

	// one-cycle write; any mode code may be written from any mode
	task write_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		addr  <= a;
		wdata <= d;
		wr    <= 1'b1;
		@(posedge clk);
		wr    <= 1'b0;
		// released lines show the inverse so stale values never pass
		addr  <= ~a;
		wdata <= ~d;
	endtask : write_reg

	// one-cycle read; data taken in the following cycle only
	task read_reg(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		addr <= a;
		rd   <= 1'b1;
		@(posedge clk);
		rd   <= 1'b0;
		addr <= ~a;
		@(posedge clk);
		d = rdata;
	endtask : read_reg
endmodule : swp_host_model

// file: tb/testbench.sv
`timescale 1ns/10ps
// self-checking bench for the power-mode controller
module testbench;
	import swp_pkg::*;
	localparam int PP = 50;  // shortened pulse period
	localparam int SU = 4;   // shortened go-sleep unit

	logic       clk, resetn, wr, rd, link_attempt, an_enable;
	logic       pll_en, mac_en, host_if_en, energy_det_en, low_power, line_pulse;
	logic [7:0] addr, wdata, rdata, rv;
	logic [1:0] energy, miim_pdown, phy_tx_en, phy_rx_en;
	int         err_total, tests_run, cyc;

	swp_host_model u_host (.clk(clk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata(rdata));

	swp_power_ctrl #(.PULSE_PERIOD(PP), .SLEEP_UNIT(SU)) u_dut (
		.clk(clk), .resetn(resetn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata(rdata), .energy(energy), .link_attempt(link_attempt),
		.an_enable(an_enable), .miim_pdown(miim_pdown), .pll_en(pll_en),
		.mac_en(mac_en), .host_if_en(host_if_en), .phy_tx_en(phy_tx_en),
		.phy_rx_en(phy_rx_en), .energy_det_en(energy_det_en),
		.low_power(low_power), .line_pulse(line_pulse));

	// clock and hang guard
	always #12.5 clk = ~clk;
	always @(posedge clk) begin
		cyc = cyc + 1;
		if (cyc == 6000) begin
			err_total++;
			complete_run();
		end
	end

	// verdict and end of run
	task complete_run;
		if (err_total == 0 && tests_run > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : complete_run

	// one comparison with its own report
	task chk(input logic [7:0] got, input logic [7:0] exp, input string what);
		tests_run++;
		if (got !== exp) begin
			err_total++;
			$display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : chk

	// power outputs packed {pll,mac,ed,lp,tx[1:0],rx[1:0]}
	task chk_pwr(input logic [7:0] exp);
		chk({pll_en, mac_en, energy_det_en, low_power, phy_tx_en, phy_rx_en}, exp, "power");
	endtask : chk_pwr

	task rd_chk(input logic [7:0] a, input logic [7:0] exp);
		u_host.read_reg(a, rv);
		chk(rv, exp, "readback");
	endtask : rd_chk

	task settle;
		repeat (4) @(posedge clk);
	endtask : settle

	// reset values, normal mode outputs, unmapped read
	task t_reset;
		chk_pwr(8'hcf);
		chk({7'h00, host_if_en}, 8'h01, "host if");
		rd_chk(OFS_PWR_MODE, 8'h00);
		rd_chk(OFS_SLEEP_DLY, RST_SLEEP_DLY);
		rd_chk(OFS_P1_CTRL, 8'h00);
		rd_chk(OFS_P2_CTRL, 8'h00);
		rd_chk(8'h55, 8'h00);
	endtask : t_reset

	// per-port power-down by control bit and by management register
	task t_port_pd;
		u_host.write_reg(OFS_P1_CTRL, 8'h08);
		settle();
		chk_pwr(8'hca);
		@(posedge clk);
		miim_pdown <= 2'b10;
		settle();
		chk_pwr(8'hc0);
		u_host.write_reg(8'h30, 8'h77);
		rd_chk(OFS_P1_CTRL, 8'h08);
		u_host.write_reg(OFS_P1_CTRL, 8'h00);
		miim_pdown <= 2'b00;
		settle();
		chk_pwr(8'hcf);
	endtask : t_port_pd

	// soft power-down keeps registers and the bus, 00 brings it back
	task t_soft_pd;
		u_host.write_reg(OFS_PWR_MODE, 8'h02);
		settle();
		chk_pwr(8'h10);
		chk({7'h00, host_if_en}, 8'h00, "host if soft pd");
		u_host.write_reg(OFS_SLEEP_DLY, 8'h03);
		rd_chk(OFS_SLEEP_DLY, 8'h03);
		rd_chk(OFS_PWR_MODE, 8'h82);
		u_host.write_reg(OFS_PWR_MODE, 8'h00);
		settle();
		chk_pwr(8'hcf);
	endtask : t_soft_pd

	// energy detect: idle sleep, line pulses, wake, optional pll stop
	task t_energy(input logic pd);
		int n, w, g;
		@(posedge clk);
		energy <= 2'b00;
		u_host.write_reg(OFS_SLEEP_DLY, 8'h02);
		u_host.write_reg(OFS_PWR_MODE, {5'h00, pd, 2'b01});
		for (n = 0; n < 60 && low_power !== 1'b1; n++) @(posedge clk);
		// three idle units beat a delay of two, plus five edges of register stages
		chk(8'(n >= 3 * SU + 4 && n <= 3 * SU + 6), 8'h01, "sleep delay");
		@(posedge clk);
		chk_pwr(pd ? 8'h30 : 8'hb0);
		chk({7'h00, host_if_en}, 8'h00, "host if asleep");
		// the first pulse starts with sleep itself, so time the next whole one
		for (n = 0; n < 20 && line_pulse !== 1'b0; n++) @(posedge clk);
		for (n = 0; n < PP + 10 && line_pulse !== 1'b1; n++) @(posedge clk);
		for (w = 0; w < 20 && line_pulse === 1'b1; w++) @(posedge clk);
		for (g = 0; g < PP + 10 && line_pulse !== 1'b1; g++) @(posedge clk);
		chk(8'(w), 8'(PULSE_WIDTH_CYC), "pulse width");
		chk(8'(w + g), 8'(PP), "pulse period");
		rd_chk(OFS_PWR_MODE, {5'h10, pd, 2'b01});
		@(posedge clk);
		energy <= 2'b01;
		settle();
		chk_pwr(8'hcf);
		chk({7'h00, line_pulse}, 8'h00, "pulse while awake");
		u_host.write_reg(OFS_PWR_MODE, 8'h00);
		settle();
	endtask : t_energy

	// power saving: entry conditions, receiver-only gating, wake causes
	task t_pwr_save;
		@(posedge clk);
		an_enable <= 1'b1;
		energy    <= 2'b00;
		u_host.write_reg(OFS_PWR_MODE, 8'h03);
		settle();
		chk_pwr(8'hfc);
		chk({7'h00, host_if_en}, 8'h01, "host if saving");
		rd_chk(OFS_PWR_MODE, 8'h83);
		link_attempt <= 1'b1;
		settle();
		chk_pwr(8'hcf);
		link_attempt <= 1'b0;
		settle();
		chk_pwr(8'hfc);
		energy <= 2'b10;
		settle();
		chk_pwr(8'hcf);
		energy    <= 2'b00;
		an_enable <= 1'b0;
		settle();
		chk_pwr(8'hcf);
		an_enable <= 1'b1;
		u_host.write_reg(OFS_PWR_MODE, 8'h02);
		settle();
		chk_pwr(8'h10);
		u_host.write_reg(OFS_PWR_MODE, 8'h00);
		settle();
		chk_pwr(8'hcf);
	endtask : t_pwr_save

	// reset in mid-run returns the mode field to normal
	task t_rereset;
		u_host.write_reg(OFS_PWR_MODE, 8'h02);
		settle();
		chk_pwr(8'h10);
		resetn <= 1'b0;
		repeat (2) @(posedge clk);
		resetn <= 1'b1;
		repeat (3) @(posedge clk);
		rd_chk(OFS_PWR_MODE, 8'h00);
		chk_pwr(8'hcf);
		rd_chk(OFS_SLEEP_DLY, RST_SLEEP_DLY);
	endtask : t_rereset

	// main sequence
	initial begin
		clk          = 1'b0;
		resetn       = 1'b0;
		energy       = 2'b11;
		miim_pdown   = 2'b00;
		link_attempt = 1'b0;
		an_enable    = 1'b0;
		err_total    = 0;
		tests_run    = 0;
		cyc          = 0;
		repeat (2) @(posedge clk);
		resetn <= 1'b1;
		repeat (3) @(posedge clk);
		t_reset();
		t_port_pd();
		t_soft_pd();
		t_energy(1'b0);
		t_energy(1'b1);
		t_pwr_save();
		t_rereset();
		complete_run();
	end
endmodule : testbench
